// ### emp_port_map.vh
// Operation
// - Address held when no external access
// - Data bus floats while grant asserted
// - Program select only on program accesses
// - Data select only on data accesses
// - Space selector marks X or Y
// - Read strobe on external reads
// - Write strobe on external writes
// - Control outputs tri-stated during reset
// - Bus request floats port after instruction
// - Grant asserted only after port released
// - Wait input stretches access while asserted
// - Grant pin becomes bus strobe
// - Mode pins latched when reset ends
// - Mode pins become interrupt inputs later
// - Interrupts level or falling-edge selectable
// - Software may change latched mode
// - Reset initialises; mode pins stay inputs
`ifndef EMP_PORT_MAP_VH
`define EMP_PORT_MAP_VH
`define EMP_ADDR_W 16
`define EMP_DATA_W 24
`define EMP_MODE_W 8
`define EMP_MODE_RST 8'h00
`define EMP_MODE_BUS_STROBE 7
`define EMP_MODE_A 0
`define EMP_MODE_B 1
`define EMP_ACCESS_CYC 1
`endif

// ### emp_port.v
`timescale 1ns/10ps
`default_nettype none
`include "emp_port_map.vh"
module emp_port #(
    parameter ADDR_W = `EMP_ADDR_W,
    parameter DATA_W = `EMP_DATA_W
) (
    input wire clk_sys_i,
    input wire nrst_i,
    input wire req_valid_i,
    input wire req_write_i,
    input wire req_prog_i,
    input wire req_y_i,
    input wire [ADDR_W-1:0] req_addr_i,
    input wire [DATA_W-1:0] req_wdata_i,
    input wire instr_end_i,
    input wire mode_wr_i,
    input wire [`EMP_MODE_W-1:0] mode_wdata_i,
    input wire [1:0] irq_edge_sel_i,
    input wire irq_ack_i,
    input wire mode_select_a_i,
    input wire mode_select_b_i,
    input wire bus_request_in_n_i,
    input wire [DATA_W-1:0] data_i,
    output reg req_ready_o,
    output reg [DATA_W-1:0] rdata_o,
    output reg rdata_valid_o,
    output reg [`EMP_MODE_W-1:0] operating_mode_reg_o,
    output reg [1:0] ext_irq_o,
    output reg [ADDR_W-1:0] addr_o,
    output reg addr_oe_o,
    output reg [DATA_W-1:0] data_o,
    output reg data_oe_o,
    output reg program_space_select_n_o,
    output reg data_space_select_n_o,
    output reg x_not_y_o,
    output reg read_strobe_n_o,
    output reg write_strobe_n_o,
    output reg ctrl_oe_o,
    output reg bus_grant_out_n_o,
    output reg bus_grant_oe_o
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_ACC = 4'b0010;
    localparam ST_REL = 4'b0100;
    localparam ST_GNT = 4'b1000;

    reg [3:0] state_q;
    reg in_reset_q;
    reg [1:0] irq_prev_q;
    reg [1:0] irq_edge_q;
    reg cur_write_q;
    wire strobe_mode;
    wire req_bus;
    wire [1:0] irq_pins;

    // Falling-edge latch per pin; a new edge wins over an acknowledge in the same cycle
    function [1:0] emp_edge_next;
        input [1:0] held;
        input ack;
        input [1:0] prev;
        input [1:0] pins;
        begin
            emp_edge_next = (held & {2{~ack}}) | (prev & ~pins);
        end
    endfunction

    assign strobe_mode = operating_mode_reg_o[`EMP_MODE_BUS_STROBE];
    assign req_bus = ~bus_request_in_n_i & ~strobe_mode;
    assign irq_pins = {mode_select_b_i, mode_select_a_i};

    always @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            state_q <= ST_IDLE;
            in_reset_q <= 1'b1;
            operating_mode_reg_o <= `EMP_MODE_RST;
            irq_prev_q <= 2'b11;
            irq_edge_q <= 2'b00;
            ext_irq_o <= 2'b00;
            cur_write_q <= 1'b0;
            req_ready_o <= 1'b0;
            rdata_o <= {DATA_W{1'b0}};
            rdata_valid_o <= 1'b0;
            addr_o <= {ADDR_W{1'b0}};
            addr_oe_o <= 1'b0;
            data_o <= {DATA_W{1'b0}};
            data_oe_o <= 1'b0;
            program_space_select_n_o <= 1'b1;
            data_space_select_n_o <= 1'b1;
            x_not_y_o <= 1'b1;
            read_strobe_n_o <= 1'b1;
            write_strobe_n_o <= 1'b1;
            ctrl_oe_o <= 1'b0;
            bus_grant_out_n_o <= 1'b1;
            bus_grant_oe_o <= 1'b0;
        end else begin
            in_reset_q <= 1'b0;
            rdata_valid_o <= 1'b0;
            req_ready_o <= 1'b0;
            if (in_reset_q) begin
                // First cycle after release: capture mode straps
                operating_mode_reg_o[`EMP_MODE_A] <= mode_select_a_i;
                operating_mode_reg_o[`EMP_MODE_B] <= mode_select_b_i;
                irq_prev_q <= irq_pins;
                addr_oe_o <= 1'b1;
                ctrl_oe_o <= 1'b1;
                bus_grant_oe_o <= 1'b1;
            end else begin
                if (mode_wr_i) begin
                    operating_mode_reg_o <= mode_wdata_i;
                end
                irq_prev_q <= irq_pins;
                // Edge latch: set wins over acknowledge
                irq_edge_q <= emp_edge_next(irq_edge_q, irq_ack_i, irq_prev_q, irq_pins);
                ext_irq_o <= (irq_edge_sel_i
                              & emp_edge_next(irq_edge_q, irq_ack_i, irq_prev_q, irq_pins))
                             | (~irq_edge_sel_i & ~irq_pins);
                case (state_q)
                    ST_IDLE: begin
                        if (req_bus && instr_end_i) begin
                            state_q <= ST_REL;
                            addr_oe_o <= 1'b0;
                            data_oe_o <= 1'b0;
                            ctrl_oe_o <= 1'b0;
                        end else if (req_valid_i) begin
                            state_q <= ST_ACC;
                            cur_write_q <= req_write_i;
                            addr_o <= req_addr_i;
                            data_o <= req_wdata_i;
                            data_oe_o <= req_write_i;
                            program_space_select_n_o <= ~req_prog_i;
                            data_space_select_n_o <= req_prog_i;
                            x_not_y_o <= req_prog_i | ~req_y_i;
                            read_strobe_n_o <= req_write_i;
                            write_strobe_n_o <= ~req_write_i;
                            bus_grant_out_n_o <= ~strobe_mode;
                        end
                    end
                    ST_ACC: begin
                        // Wait pin holds the cycle open in strobe mode
                        if (!(strobe_mode && !bus_request_in_n_i)) begin
                            state_q <= ST_IDLE;
                            req_ready_o <= 1'b1;
                            rdata_o <= data_i;
                            rdata_valid_o <= ~cur_write_q;
                            data_oe_o <= 1'b0;
                            program_space_select_n_o <= 1'b1;
                            data_space_select_n_o <= 1'b1;
                            read_strobe_n_o <= 1'b1;
                            write_strobe_n_o <= 1'b1;
                            bus_grant_out_n_o <= 1'b1;
                        end
                    end
                    ST_REL: begin
                        state_q <= ST_GNT;
                        bus_grant_out_n_o <= 1'b0;
                    end
                    ST_GNT: begin
                        if (!req_bus) begin
                            state_q <= ST_IDLE;
                            bus_grant_out_n_o <= 1'b1;
                            addr_oe_o <= 1'b1;
                            ctrl_oe_o <= 1'b1;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // emp_port
`default_nettype wire

// ### emp_port_props.sv
`timescale 1ns/10ps
`default_nettype none
module emp_port_props (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic req_write_i,
    input wire logic req_prog_i,
    input wire logic mode_select_a_i,
    input wire logic mode_select_b_i,
    input wire logic bus_request_in_n_i,
    input wire logic [15:0] addr_o,
    input wire logic data_oe_o,
    input wire logic program_space_select_n_o,
    input wire logic read_strobe_n_o,
    input wire logic write_strobe_n_o,
    input wire logic ctrl_oe_o,
    input wire logic bus_grant_out_n_o,
    input wire logic bus_grant_oe_o,
    input wire logic [7:0] operating_mode_reg_o
);
    wire m7 = operating_mode_reg_o[7];
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    chk_addr_hold: assert property (read_strobe_n_o && write_strobe_n_o |-> $stable(addr_o))
        else $error("address moved while idle");
    chk_data_float: assert property (!m7 && !bus_grant_out_n_o |-> !data_oe_o)
        else $error("data driven during grant");
    chk_prog_sel: assert property ($fell(program_space_select_n_o) |-> $past(req_prog_i))
        else $error("program select on data access");
    chk_wr_strobe: assert property ($fell(write_strobe_n_o) |-> $past(req_write_i) && data_oe_o)
        else $error("write strobe without write");
    chk_reset_float: assert property (disable iff (1'b0) !nrst_i |=> !ctrl_oe_o && !bus_grant_oe_o)
        else $error("controls driven in reset");
    chk_grant_release: assert property (!m7 && $fell(bus_grant_out_n_o) |-> !$past(ctrl_oe_o))
        else $error("grant before release");
    chk_bus_strobe: assert property (m7 && !read_strobe_n_o |-> !bus_grant_out_n_o)
        else $error("bus strobe missing during access");
    chk_wait_stretch: assert property (m7 && !read_strobe_n_o && !bus_request_in_n_i |=> !read_strobe_n_o)
        else $error("access ended under wait");
    chk_mode_latch: assert property (nrst_i && !$past(nrst_i) |=>
        operating_mode_reg_o == {6'h0, $past(mode_select_b_i), $past(mode_select_a_i)})
        else $error("straps not latched");
    cov_wait: cover property (m7 && !read_strobe_n_o && !bus_request_in_n_i);
    cov_grant: cover property (!m7 && !bus_grant_out_n_o);
    cov_write: cover property ($fell(write_strobe_n_o));
endmodule // emp_port_props
bind emp_port emp_port_props emp_port_props_inst (.*);
`default_nettype wire

// ### emp_port_mem.sv
`timescale 1ns/10ps
`default_nettype none
module emp_port_mem (
    input wire logic clk_sys_i,
    input wire logic [15:0] addr_i,
    input wire logic [23:0] wdata_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    output logic [23:0] rdata_o
);
    logic [23:0] mem_q [0:15];
    logic [23:0] last_q = 24'h0;
    // Idle bus shows the inverse of the last word read
    assign rdata_o = rd_n_i ? ~last_q : mem_q[addr_i[3:0]];
    always @(posedge clk_sys_i) begin
        if (!wr_n_i) mem_q[addr_i[3:0]] <= wdata_i;
        if (!rd_n_i) last_q <= mem_q[addr_i[3:0]];
    end
endmodule // emp_port_mem
`default_nettype wire

// ### test_emp_port.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module test_emp_port;
    logic clk_sys_i = 0, nrst_i = 0, req_valid_i = 0, req_write_i = 0, req_prog_i = 0;
    logic req_y_i = 0, mode_wr_i = 0, irq_ack_i = 0, bus_request_in_n_i = 1;
    logic mode_select_a_i = 1, mode_select_b_i = 1;
    logic [15:0] req_addr_i = 16'h0, addr_o;
    logic [23:0] req_wdata_i = 24'h0, data_i, rdata_o, data_o;
    logic [7:0] mode_wdata_i = 8'h0, operating_mode_reg_o;
    logic [1:0] irq_edge_sel_i = 2'b10, ext_irq_o;
    logic req_ready_o, rdata_valid_o, addr_oe_o, data_oe_o, program_space_select_n_o;
    logic data_space_select_n_o, x_not_y_o, read_strobe_n_o, write_strobe_n_o;
    logic ctrl_oe_o, bus_grant_out_n_o, bus_grant_oe_o;
    integer mismatches = 0, comparisons = 0;
    emp_port emp_port_inst (.instr_end_i(1'b1), .*);
    emp_port_mem emp_port_mem_inst (.clk_sys_i, .addr_i(addr_o), .wdata_i(data_o),
        .rd_n_i(read_strobe_n_o), .wr_n_i(write_strobe_n_o), .rdata_o(data_i));
    initial forever #25 clk_sys_i = ~clk_sys_i;
    task wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task acc(input logic w, p, y, input logic [15:0] a, input logic [23:0] d,
        output logic [23:0] q);
        integer n;
        {req_write_i, req_prog_i, req_y_i, req_addr_i, req_wdata_i} = {w, p, y, a, d};
        req_valid_i = 1;
        n = 0;
        do begin @(posedge clk_sys_i); #1; n++; end while (req_ready_o !== 1'b1 && n < 20);
        if (req_ready_o !== 1'b1) mismatches++;
        q = rdata_o;
        @(negedge clk_sys_i) req_valid_i = 0;
        @(negedge clk_sys_i);
    endtask
    task t_mem;
        logic [23:0] q;
        logic [1:0] k;
        for (k = 0; k < 3; k++) acc(1, k == 0, k == 2, {14'h0, k}, {8'h5a, 14'h0, k}, q);
        for (k = 0; k < 3; k++) begin
            acc(0, k == 0, k == 2, {14'h0, k}, 24'h0, q);
            `CHK("rdata", {8'h5a, 14'h0, k}, q)
        end
        repeat (3) @(negedge clk_sys_i);
        `CHK("addr", 16'h2, addr_o)
        $display("t_mem end");
    endtask
    task t_busreq;
        bus_request_in_n_i = 0;
        repeat (3) @(negedge clk_sys_i);
        `CHK("grant", 1'b0, bus_grant_out_n_o)
        `CHK("port_oe", 1'b0, ctrl_oe_o | addr_oe_o | data_oe_o)
        bus_request_in_n_i = 1;
        repeat (2) @(negedge clk_sys_i);
        `CHK("regain", 2'b11, {bus_grant_out_n_o, ctrl_oe_o})
        $display("t_busreq end");
    endtask
    task t_wait;
        logic [23:0] q;
        time t0;
        mode_wdata_i = 8'h80;
        mode_wr_i = 1;
        @(negedge clk_sys_i) mode_wr_i = 0;
        @(negedge clk_sys_i);
        `CHK("mode", 8'h80, operating_mode_reg_o)
        bus_request_in_n_i = 0;
        t0 = $time;
        fork
            acc(0, 0, 0, 16'h1, 24'h0, q);
            begin repeat (4) @(negedge clk_sys_i); bus_request_in_n_i = 1; end
        join
        `CHK("wait_rdata", 24'h5a0001, q)
        `CHK("stretch", 1'b1, $time - t0 > 250)
        $display("t_wait end");
    endtask
    task t_irq;
        {mode_select_a_i, mode_select_b_i} = 2'b00;
        repeat (3) @(negedge clk_sys_i);
        `CHK("irq", 2'b11, ext_irq_o)
        {mode_select_a_i, mode_select_b_i} = 2'b11;
        repeat (3) @(negedge clk_sys_i);
        `CHK("irq_hold", 2'b10, ext_irq_o)
        irq_ack_i = 1;
        @(negedge clk_sys_i) irq_ack_i = 0;
        repeat (2) @(negedge clk_sys_i);
        `CHK("irq_ack", 2'b00, ext_irq_o)
        $display("t_irq end");
    endtask
    initial begin
        #20000 mismatches++;
        wrap_up;
    end
    initial begin
        repeat (3) @(negedge clk_sys_i);
        `CHK("rst_oe", 1'b0, ctrl_oe_o | bus_grant_oe_o)
        nrst_i = 1; // Straps held high through reset
        repeat (2) @(negedge clk_sys_i);
        `CHK("mode_rst", 8'h03, operating_mode_reg_o)
        t_mem;
        t_busreq;
        t_wait;
        t_irq;
        wrap_up;
    end
endmodule // test_emp_port
`default_nettype wire
